// file: nvc_host.sv
/*
 * nvc_host: host controller driving an asynchronous nonvolatile SRAM over its
 * pins: reads, byte writes, command read sequences and hardware store.
 * Assumes the memory pins sit outside this clock domain, a 40 MHz ref_clk
 * and a user that holds a request until req_ready.
 */
// Summary of operation
// - output enable stays high through every write cycle.
// - commands are six consecutive reads in exact order, write strobe high.
// - hardware save request: busy line low at least 15 ns.
// - write strobe stays inactive during the power-up restore.
`timescale 1ns/1ps
`include "nvc_map.svh"

module nvc_host
  import nvc_pkg::*;
#(
  parameter int CNT_W     = 20,
  parameter int RD_CYC    = `NVC_RD_CYC,
  parameter int WR_CYC    = `NVC_WR_CYC,
  parameter int HWR_CYC   = `NVC_HWR_CYC,
  parameter int SS_CYC    = `NVC_SS_CYC,
  parameter int DELAY_CYC = `NVC_DELAY_CYC,
  parameter int RECALL_CYC = `NVC_RECALL_CYC,
  parameter int STORE_CYC = `NVC_STORE_CYC,
  parameter int PWRUP_CYC = `NVC_PWRUP_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire nvc_cmd_t    req_cmd,
  input  wire logic [17:0] req_addr,
  input  wire logic [15:0] req_wdata,
  input  wire logic [1:0]  req_byte_en,
  output logic [15:0]      rsp_rdata,
  output logic             rsp_valid,
  output logic             op_done,
  output logic             op_timeout,
  output logic             nv_busy,
  output logic             chip_select_n,
  output logic             output_en_n,
  output logic             write_strobe_n,
  output logic             upper_byte_en_n,
  output logic             low_byte_en_n,
  output logic [17:0]      word_addr,
  input  wire logic [15:0] data_io_i,
  output logic [15:0]      data_io_o,
  output logic             data_io_oe,
  input  wire logic        store_busy_n_i,
  output logic             store_busy_n_o,
  output logic             store_busy_n_oe
);

  // ***********************************************************************
  // parameter checks
  // ***********************************************************************
  if (RD_CYC < 1 || WR_CYC < 1 || HWR_CYC < 1 || SS_CYC < 1 || DELAY_CYC < 1 ||
      STORE_CYC < 1 || PWRUP_CYC < 1 || CNT_W > 31 ||
      SS_CYC + RECALL_CYC >= 2**CNT_W || STORE_CYC >= 2**CNT_W ||
      PWRUP_CYC >= 2**CNT_W || DELAY_CYC >= 2**CNT_W)
  begin : g_bad_param
    $error("nvc_host: count parameter out of range");
  end

  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    nvc_state_t       st;
    nvc_cmd_t         cmd;
    logic             seq;
    logic [2:0]       step;
    logic [CNT_W-1:0] cnt;
    logic             cs_n;
    logic             oe_n;
    logic             we_n;
    logic             hi_n;
    logic             lo_n;
    logic [17:0]      addr;
    logic [15:0]      dout;
    logic             doe;
    logic             hwr_oe;
    logic [15:0]      rdata;
    logic             rvalid;
    logic             done;
    logic             tmo;
  } nvc_host_st_t;

  localparam nvc_host_st_t RST_ST = '{
    st: ST_PWRUP, cmd: NVC_RD, seq: 1'b0, step: 3'h0, cnt: '0,
    cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, hi_n: 1'b1, lo_n: 1'b1,
    addr: 18'h0_0000, dout: 16'h0000, doe: 1'b0, hwr_oe: 1'b0,
    rdata: 16'h0000, rvalid: 1'b0, done: 1'b0, tmo: 1'b0};

  nvc_host_st_t st_r;
  nvc_host_st_t st_nxt;
  logic [15:0]  din_s;
  logic         busy_n_s;

  // ***********************************************************************
  // pin inputs
  // ***********************************************************************
  nvc_sync #(
    .W       (17),
    .RST_VAL (17'h1_FFFF)
  ) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .d       ({store_busy_n_i, data_io_i}),
    .q       ({busy_n_s, din_s})
  );

  // ***********************************************************************
  // helpers
  // ***********************************************************************
  // upper two address bits are zero; the detector ignores them anyway
  function automatic logic [17:0] seq_addr(input logic [2:0] step, input nvc_cmd_t cmd);
    logic [17:0] a;
    a = `NVC_SEQ_A0;
    unique case (step)
      3'h0: a = `NVC_SEQ_A0;
      3'h1: a = `NVC_SEQ_A1;
      3'h2: a = `NVC_SEQ_A2;
      3'h3: a = `NVC_SEQ_A3;
      3'h4: a = `NVC_SEQ_A4;
      default:
        unique case (cmd)
          NVC_SSTORE:   a = `NVC_SEQ_STORE;
          NVC_SRESTORE: a = `NVC_SEQ_RESTORE;
          NVC_PLS_OFF:  a = `NVC_SEQ_PLS_OFF;
          default:      a = `NVC_SEQ_PLS_ON;
        endcase
    endcase
    return a;
  endfunction

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return CNT_W'(n - 1);
  endfunction

  // ***********************************************************************
  // sequencer
  // ***********************************************************************
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.done   = 1'b0;
    st_nxt.tmo    = 1'b0;
    unique case (st_r.st)
      ST_PWRUP:
      begin
        // strobes parked high while the memory restores itself
        if (st_r.cnt == cyc(PWRUP_CYC))
          st_nxt.st = ST_IDLE;
        else
          st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
      ST_IDLE:
      begin
        // nothing starts while the memory reports busy
        if (req_valid && busy_n_s)
        begin
          st_nxt.cmd  = req_cmd;
          st_nxt.seq  = 1'b0;
          st_nxt.step = 3'h0;
          unique case (req_cmd)
            NVC_RD:
            begin
              st_nxt.st   = ST_RD;
              st_nxt.cs_n = 1'b0;
              st_nxt.oe_n = 1'b0;
              st_nxt.addr = req_addr;
              st_nxt.hi_n = !req_byte_en[1];
              st_nxt.lo_n = !req_byte_en[0];
              st_nxt.cnt  = cyc(RD_CYC + `NVC_SYNC_CYC);
            end
            NVC_WR:
            begin
              st_nxt.st   = ST_WR;
              st_nxt.cs_n = 1'b0;
              st_nxt.we_n = 1'b0;
              st_nxt.oe_n = 1'b1;
              st_nxt.doe  = 1'b1;
              st_nxt.dout = req_wdata;
              st_nxt.addr = req_addr;
              st_nxt.hi_n = !req_byte_en[1];
              st_nxt.lo_n = !req_byte_en[0];
              st_nxt.cnt  = cyc(WR_CYC);
            end
            NVC_HSTORE:
            begin
              st_nxt.st     = ST_HWR;
              st_nxt.hwr_oe = 1'b1;
              st_nxt.cnt    = cyc(HWR_CYC);
            end
            default:
            begin
              // command sequence: reads only, full word enabled
              st_nxt.st   = ST_RD;
              st_nxt.seq  = 1'b1;
              st_nxt.cs_n = 1'b0;
              st_nxt.oe_n = 1'b0;
              st_nxt.hi_n = 1'b0;
              st_nxt.lo_n = 1'b0;
              st_nxt.addr = seq_addr(3'h0, req_cmd);
              st_nxt.cnt  = cyc(RD_CYC + `NVC_SYNC_CYC);
            end
          endcase
        end
      end
      ST_RD:
      begin
        if (st_r.cnt == '0)
        begin
          // raising select gives the next read its own falling edge
          st_nxt.st   = ST_RD_GAP;
          st_nxt.cs_n = 1'b1;
          st_nxt.oe_n = 1'b1;
          if (!st_r.seq)
          begin
            st_nxt.rdata  = din_s;
            st_nxt.rvalid = 1'b1;
          end
        end
        else
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
      ST_RD_GAP:
      begin
        if (st_r.seq && st_r.step != `NVC_SEQ_LAST)
        begin
          st_nxt.st   = ST_RD;
          st_nxt.step = 3'(st_r.step + 3'h1);
          st_nxt.cs_n = 1'b0;
          st_nxt.oe_n = 1'b0;
          st_nxt.addr = seq_addr(3'(st_r.step + 3'h1), st_r.cmd);
          st_nxt.cnt  = cyc(RD_CYC + `NVC_SYNC_CYC);
        end
        else if (st_r.seq)
        begin
          st_nxt.st = ST_WAIT;
          if (st_r.cmd == NVC_SRESTORE)
            st_nxt.cnt = cyc(SS_CYC + RECALL_CYC);
          else
            st_nxt.cnt = cyc(SS_CYC);
        end
        else
        begin
          st_nxt.st   = ST_IDLE;
          st_nxt.done = 1'b1;
        end
      end
      ST_WR:
      begin
        if (st_r.cnt == '0)
        begin
          st_nxt.st   = ST_WR_GAP;
          st_nxt.cs_n = 1'b1;
          st_nxt.we_n = 1'b1;
        end
        else
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
      ST_WR_GAP:
      begin
        // data held one cycle past the strobe edge for hold time
        st_nxt.st   = ST_IDLE;
        st_nxt.doe  = 1'b0;
        st_nxt.done = 1'b1;
      end
      ST_HWR:
      begin
        if (st_r.cnt == '0)
        begin
          st_nxt.hwr_oe = 1'b0;
          st_nxt.st     = ST_WAIT;
          st_nxt.cnt    = cyc(DELAY_CYC);
        end
        else
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
      ST_WAIT:
      begin
        if (st_r.cnt == '0)
        begin
          if (st_r.cmd == NVC_SSTORE || st_r.cmd == NVC_HSTORE)
          begin
            st_nxt.st  = ST_BUSY;
            st_nxt.cnt = cyc(STORE_CYC);
          end
          else
          begin
            st_nxt.st   = ST_IDLE;
            st_nxt.done = 1'b1;
          end
        end
        else
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
      ST_BUSY:
      begin
        // a hardware save may be skipped, so busy high also ends the wait
        if (busy_n_s || st_r.cnt == '0)
        begin
          st_nxt.st   = ST_IDLE;
          st_nxt.done = 1'b1;
          st_nxt.tmo  = !busy_n_s;
        end
        else
          st_nxt.cnt = st_r.cnt - CNT_W'(1);
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= RST_ST;
    else
      st_r <= st_nxt;
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign req_ready       = (st_r.st == ST_IDLE) && busy_n_s;
  assign rsp_rdata       = st_r.rdata;
  assign rsp_valid       = st_r.rvalid;
  assign op_done         = st_r.done;
  assign op_timeout      = st_r.tmo;
  assign nv_busy         = !busy_n_s;
  assign chip_select_n   = st_r.cs_n;
  assign output_en_n     = st_r.oe_n;
  assign write_strobe_n  = st_r.we_n;
  assign upper_byte_en_n = st_r.hi_n;
  assign low_byte_en_n   = st_r.lo_n;
  assign word_addr       = st_r.addr;
  assign data_io_o       = st_r.dout;
  assign data_io_oe      = st_r.doe;
  assign store_busy_n_o  = 1'b0;
  assign store_busy_n_oe = st_r.hwr_oe;

  // ***********************************************************************
  // assertions
  // ***********************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_oe_high_in_write;
    !write_strobe_n |-> output_en_n && data_io_oe;
  endproperty
  a_oe_high_in_write: assert property (p_oe_high_in_write)
    else $error("output enable low during write");

  property p_read_strobes;
    !chip_select_n && write_strobe_n |-> !output_en_n && !data_io_oe;
  endproperty
  a_read_strobes: assert property (p_read_strobes)
    else $error("read without output enable");

  property p_write_width;
    $fell(write_strobe_n) |-> (!write_strobe_n && !chip_select_n)[*2] ##1 write_strobe_n;
  endproperty
  a_write_width: assert property (p_write_width)
    else $error("write strobe width wrong");

  property p_seq_we_high;
    st_r.seq && st_r.st != ST_IDLE |-> write_strobe_n;
  endproperty
  a_seq_we_high: assert property (p_seq_we_high)
    else $error("write strobe low inside command sequence");

  property p_seq_first_addr;
    $fell(chip_select_n) && st_r.seq && st_r.step == 3'h0 |-> word_addr == `NVC_SEQ_A0;
  endproperty
  a_seq_first_addr: assert property (p_seq_first_addr)
    else $error("command sequence started at wrong address");

  property p_store_last_addr;
    $fell(chip_select_n) && st_r.seq && st_r.step == `NVC_SEQ_LAST && st_r.cmd == NVC_SSTORE
      |-> word_addr == `NVC_SEQ_STORE;
  endproperty
  a_store_last_addr: assert property (p_store_last_addr)
    else $error("save sequence ended at wrong address");

  property p_start_not_busy;
    $fell(chip_select_n) && !st_r.seq |-> $past(busy_n_s);
  endproperty
  a_start_not_busy: assert property (p_start_not_busy)
    else $error("access started while memory busy");

  property p_hwr_pulse;
    $rose(store_busy_n_oe) |=> !store_busy_n_oe ##1 st_r.st == ST_WAIT;
  endproperty
  a_hwr_pulse: assert property (p_hwr_pulse)
    else $error("hardware save pulse width wrong");

  property p_pwrup_quiet;
    st_r.st == ST_PWRUP |-> write_strobe_n && chip_select_n && !req_ready;
  endproperty
  a_pwrup_quiet: assert property (p_pwrup_quiet)
    else $error("memory touched during power-up restore");

endmodule

// file: nvc_map.svh
/*
 * nvc_map.svh: pin timing, wait counts and command address sequence for the
 * nonvolatile SRAM host controller.
 * Assumes a 25 ns controller clock and the slowest speed grade of the memory.
 */
`ifndef NVC_MAP_SVH
`define NVC_MAP_SVH

// ***********************************************************************
// clock and rounding
// ***********************************************************************
`define NVC_CLK_NS          25
`define NVC_CYC_UP(ns)      ((((ns) + `NVC_CLK_NS - 1) / `NVC_CLK_NS))

// ***********************************************************************
// pin cycle times, ns
// ***********************************************************************
`define NVC_T_ACC_NS        45
`define NVC_T_WP_NS         30
`define NVC_T_HWR_NS        15
`define NVC_SYNC_CYC        2
`define NVC_RD_CYC          `NVC_CYC_UP(`NVC_T_ACC_NS)
`define NVC_WR_CYC          `NVC_CYC_UP(`NVC_T_WP_NS)
`define NVC_HWR_CYC         `NVC_CYC_UP(`NVC_T_HWR_NS)

// ***********************************************************************
// long waits, us, and their counts
// ***********************************************************************
`define NVC_T_SS_US         70
`define NVC_T_DELAY_US      70
`define NVC_T_RECALL_US     150
`define NVC_T_STORE_US      12500
`define NVC_T_PWRUP_US      20000
`define NVC_SS_CYC          `NVC_CYC_UP(`NVC_T_SS_US * 1000)
`define NVC_DELAY_CYC       `NVC_CYC_UP(`NVC_T_DELAY_US * 1000)
`define NVC_RECALL_CYC      `NVC_CYC_UP(`NVC_T_RECALL_US * 1000)
`define NVC_STORE_CYC       `NVC_CYC_UP(`NVC_T_STORE_US * 1000)
`define NVC_PWRUP_CYC       `NVC_CYC_UP(`NVC_T_PWRUP_US * 1000)

// ***********************************************************************
// command read sequence
// ***********************************************************************
`define NVC_SEQ_A0          18'h0_4E38
`define NVC_SEQ_A1          18'h0_B1C7
`define NVC_SEQ_A2          18'h0_83E0
`define NVC_SEQ_A3          18'h0_7C1F
`define NVC_SEQ_A4          18'h0_703F
`define NVC_SEQ_STORE       18'h0_8FC0
`define NVC_SEQ_RESTORE     18'h0_4C63
`define NVC_SEQ_PLS_OFF     18'h0_8B45
`define NVC_SEQ_PLS_ON      18'h0_4B46
`define NVC_SEQ_LAST        3'h5

`endif

// file: nvc_pkg.sv
/*
 * nvc_pkg: command and state types of the nonvolatile SRAM host controller.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nvc_pkg;

  // ***********************************************************************
  // user commands
  // ***********************************************************************
  typedef enum logic [2:0] {
    NVC_RD,
    NVC_WR,
    NVC_SSTORE,
    NVC_SRESTORE,
    NVC_PLS_OFF,
    NVC_PLS_ON,
    NVC_HSTORE
  } nvc_cmd_t;

  // ***********************************************************************
  // sequencer states
  // ***********************************************************************
  typedef enum logic [3:0] {
    ST_PWRUP,
    ST_IDLE,
    ST_RD,
    ST_RD_GAP,
    ST_WR,
    ST_WR_GAP,
    ST_HWR,
    ST_WAIT,
    ST_BUSY
  } nvc_state_t;

endpackage

// file: nvc_sync.sv
/*
 * nvc_sync: two flip-flop synchroniser for pin inputs, any width.
 * Assumes each bit is sampled independently; multi-bit words must be
 * stable for several clocks before they are read.
 */
`timescale 1ns/1ps

module nvc_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } nvc_sync_st_t;

  nvc_sync_st_t st_r;
  nvc_sync_st_t st_nxt;

  // first stage feeds only the second stage
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '{s1: RST_VAL, s2: RST_VAL};
    else
      st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule

// file: nvc_dev_model.sv
/*
 * nvc_dev_model: behavioural nonvolatile SRAM for the host bench.
 * assumes the bench resolves the shared data and busy lines.
 */
`timescale 1ns/1ps

module nvc_dev_model #(
  parameter int ACC_NS = 45,
  parameter int STO_NS = 500,
  parameter int RCL_NS = 200,
  parameter int DLY_NS = 100,
  parameter int PUP_NS = 200
) (
  input  wire logic        chip_select_n,
  input  wire logic        output_en_n,
  input  wire logic        write_strobe_n,
  input  wire logic        upper_byte_en_n,
  input  wire logic        low_byte_en_n,
  input  wire logic [17:0] word_addr,
  input  wire logic [15:0] din,
  input  wire logic        busy_line,
  output logic      [15:0] dq,
  output logic             busy_pull,
  output logic             pls_en,
  output int               store_cnt
);
  // ***********************************************************
  // storage and access
  // ***********************************************************
  localparam logic [15:0] SEQ [5] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f};
  logic [15:0] sram [logic [17:0]];
  logic [15:0] nv [logic [17:0]];
  logic [15:0] last, word;
  logic [2:0]  step;
  logic        dirty, inhibit, rd_dly, wr_arm;
  wire rd_on = !chip_select_n && !output_en_n && write_strobe_n && busy_line && !inhibit;
  wire wr_on = !chip_select_n && !write_strobe_n && busy_line && !inhibit;

  // slow answer: data shows only after the access time
  assign #(ACC_NS) rd_dly = rd_on;
  always @(word_addr or rd_dly) word = sram.exists(word_addr) ? sram[word_addr] : '0;
  // released lanes show the inverse of the last word, never a stale copy
  assign dq = {(rd_dly && !upper_byte_en_n) ? word[15:8] : ~last[15:8],
               (rd_dly && !low_byte_en_n) ? word[7:0] : ~last[7:0]};
  always @(negedge rd_dly) last = word;
  // a write held across a nonvolatile cycle waits for a fresh strobe edge
  always @(negedge chip_select_n or negedge write_strobe_n) wr_arm = 1'b1;

  always @(negedge wr_on)
    if (!inhibit && wr_arm)
    begin
      if (!sram.exists(word_addr)) sram[word_addr] = '0;
      if (!upper_byte_en_n) sram[word_addr][15:8] = din[15:8];
      if (!low_byte_en_n) sram[word_addr][7:0] = din[7:0];
      dirty = 1'b1;
      step = '0;
    end

  // ***********************************************************
  // command detector and nonvolatile cycles
  // ***********************************************************
  always @(posedge rd_on)
    if (step == 3'd5)
    begin
      step = '0;
      case (word_addr[15:0])
        16'h8fc0: fork do_store(); join_none
        16'h4c63: fork do_restore(); join_none
        16'h8b45: pls_en = 1'b0;
        16'h4b46: pls_en = 1'b1;
        default: ;
      endcase
    end
    else
      step = (word_addr[15:0] == SEQ[step]) ? step + 3'd1 : 3'(word_addr[15:0] == SEQ[0]);

  task automatic do_store();
    busy_pull = 1'b1;
    inhibit = 1'b1;
    #(STO_NS / 2) nv.delete();
    #(STO_NS / 2) nv = sram;
    dirty = 1'b0;
    store_cnt++;
    wr_arm = 1'b0;
    inhibit = 1'b0;
    busy_pull = 1'b0;
  endtask

  task automatic do_restore();
    inhibit = 1'b1;
    sram.delete();
    #(RCL_NS) sram = nv;
    dirty = 1'b0;
    wr_arm = 1'b0;
    inhibit = 1'b0;
  endtask

  // hardware request only counts while the line is not our own busy
  always @(negedge busy_line)
    if (!busy_pull)
      fork
        begin
          #(DLY_NS);
          if (dirty) do_store();
        end
      join_none

  initial
  begin
    busy_pull = 1'b1;
    inhibit = 1'b1;
    pls_en = 1'b1;
    dirty = 1'b0;
    step = '0;
    store_cnt = 0;
    last = '0;
    #(PUP_NS) wr_arm = 1'b0;
    inhibit = 1'b0;
    busy_pull = 1'b0;
  end
endmodule

// file: test_nv_sram_store_recall_control.sv
/*
 * test_nv_sram_store_recall_control: self-checking bench, nvc_host against
 * nvc_dev_model. assumes shortened wait parameters.
 */
`timescale 1ns/1ps

module test_nv_sram_store_recall_control import nvc_pkg::*;;
  // ***********************************************************
  // signals and instances
  // ***********************************************************
  localparam logic [17:0] SEQ [5] = '{18'h0_4e38, 18'h0_b1c7, 18'h0_83e0, 18'h0_7c1f, 18'h0_703f};
  logic        ref_clk, rstn, req_valid, req_ready, rsp_valid, op_done, op_timeout, nv_busy;
  logic        chip_select_n, output_en_n, write_strobe_n, upper_byte_en_n, low_byte_en_n;
  logic        data_io_oe, store_busy_n_o, store_busy_n_oe, busy_pull, pls_en;
  logic [17:0] req_addr, word_addr;
  logic [15:0] req_wdata, rsp_rdata, data_io_o, dq, data_io_i;
  logic [1:0]  req_byte_en;
  logic [31:0] e, r;
  logic [31:0] seed = 32'h0000_a566;
  logic [31:0] rd_q [$];
  logic [15:0] ref_mem [logic [17:0]];
  logic [15:0] ref_nv [logic [17:0]];
  nvc_cmd_t    req_cmd;
  int          store_cnt, fails, samples_checked;
  wire         busy_line = !((store_busy_n_oe && !store_busy_n_o) || busy_pull);

  assign data_io_i = data_io_oe ? data_io_o : dq;

  nvc_host #(.PWRUP_CYC(20), .STORE_CYC(50), .SS_CYC(10), .DELAY_CYC(10), .RECALL_CYC(10))
    u_nvc_host (.*, .store_busy_n_i(busy_line));
  nvc_dev_model u_nvc_dev_model (.*, .din(data_io_o));

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ***********************************************************
  // helpers
  // ***********************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_rd(input logic [15:0] got, input logic [31:0] x);
    check({16'h0000, got & x[31:16]}, {16'h0000, x[15:0] & x[31:16]}, "read data");
  endtask

  task automatic give_verdict();
    if (fails == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // request held from a rising edge until the edge where ready is high
  task automatic do_req(input nvc_cmd_t c, input logic [17:0] a, input logic [15:0] d,
                        input logic [1:0] be);
    int n;
    n = 0;
    req_cmd <= c;
    req_addr <= a;
    req_wdata <= d;
    req_byte_en <= be;
    req_valid <= 1'b1;
    do @(negedge ref_clk); while (req_ready !== 1'b1 && ++n < 9000);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    do @(negedge ref_clk); while (op_done !== 1'b1 && ++n < 9000);
    if (n >= 9000) check(1, 0, "hang");
    @(posedge ref_clk);
  endtask

  task automatic cmd(input nvc_cmd_t c);
    do_req(c, '0, '0, '0);
  endtask

  // live low: lanes show the inverse of the last word, nothing to compare
  task automatic rd(input logic [17:0] a, input logic [1:0] be, input logic live);
    rd_q.push_back({{8{be[1] & live}}, {8{be[0] & live}},
                    ref_mem.exists(a) ? ref_mem[a] : 16'h0000});
    do_req(NVC_RD, a, '0, be);
  endtask

  task automatic wr(input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
    if (!ref_mem.exists(a)) ref_mem[a] = '0;
    if (be[1]) ref_mem[a][15:8] = d[15:8];
    if (be[0]) ref_mem[a][7:0] = d[7:0];
    do_req(NVC_WR, a, d, be);
  endtask

  // ***********************************************************
  // monitor
  // ***********************************************************
  always @(negedge ref_clk)
    if (rstn)
    begin
      if (rsp_valid === 1'b1)
      begin
        e = rd_q.pop_front();
        check_rd(rsp_rdata, e);
      end
      if (write_strobe_n === 1'b0) check(32'(output_en_n), 1, "oe in write");
      if (op_done === 1'b1) check(32'(op_timeout), 0, "save overran");
    end

  // ***********************************************************
  // scenarios
  // ***********************************************************
  initial
  begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_cmd = NVC_RD;
    req_addr = '0;
    req_wdata = '0;
    req_byte_en = '0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge ref_clk);
    check(32'(req_ready), 0, "ready in reset");
    check(32'(write_strobe_n), 1, "strobe in reset");
    check(32'(pls_en), 1, "pls default");
    rstn <= 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      wr(r[17:0], r[31:16], 2'(i + 1));
      rd(r[17:0], r[19:18], 1'b1);
    end
    cmd(NVC_HSTORE);
    ref_nv = ref_mem;
    check(store_cnt, 1, "hw save");
    cmd(NVC_HSTORE);
    check(store_cnt, 1, "clean hw save");
    cmd(NVC_SSTORE);
    ref_nv = ref_mem;
    check(store_cnt, 2, "sw save");
    wr(18'h0_0100, 16'h5a5a, 2'b11);
    cmd(NVC_SRESTORE);
    ref_mem = ref_nv;
    rd(18'h0_0100, 2'b11, 1'b1);
    cmd(NVC_HSTORE);
    check(store_cnt, 2, "save after restore");
    cmd(NVC_PLS_OFF);
    check(32'(pls_en), 0, "pls off");
    cmd(NVC_PLS_ON);
    check(32'(pls_en), 1, "pls on");
    // first pass is broken by a write, second completes a save
    for (int k = 0; k < 2; k++)
    begin
      foreach (SEQ[j]) rd(SEQ[j] | 18'h3_0000, 2'b11, 1'b1);
      if (k == 0) wr(18'h0_0200, 16'h1234, 2'b01);
      rd(18'h3_8fc0, 2'b11, k == 0);
      if (k == 1) check(32'(nv_busy), 1, "busy in save");
      rd(18'h0_0200, 2'b11, 1'b1);
      check(store_cnt, 2 + k, "raw sequence");
    end
    check(rd_q.size(), 0, "reads left");
    give_verdict();
  end

  initial
  begin
    #(25 * 20000);
    check(1, 0, "watchdog");
    give_verdict();
  end
endmodule
